// >>> logic/clk_ctrl_pkg.sv
// constants, register map and types for the clock source and fail-safe block
package clk_ctrl_pkg;

	// clock rate and times
	localparam int CLK_FREQ_KHZ   = 250_000;
	localparam int LOCK_TIME_MS   = 1;
	localparam int LOCK_CYCLES    = LOCK_TIME_MS * CLK_FREQ_KHZ;
	localparam int LIMP_FREQ_KHZ  = 3_000;
	localparam int LIMP_DIV       = CLK_FREQ_KHZ / LIMP_FREQ_KHZ;
	localparam int MISS_TIME_NS   = 1_000;
	localparam int MISS_CYCLES    = MISS_TIME_NS * (CLK_FREQ_KHZ / 1_000) / 1_000;
	localparam int WDOG_PULSE_OSC = 512;

	// widths
	localparam int MULT_W = 4;
	localparam int ADDR_W = 8;

	// register offsets
	localparam logic [7:0] OFF_SRC_CTRL   = 8'h00;
	localparam logic [7:0] OFF_EXT_CFG    = 8'h04;
	localparam logic [7:0] OFF_MULT_CTRL  = 8'h08;
	localparam logic [7:0] OFF_MULT_STATE = 8'h0C;
	localparam logic [7:0] OFF_NMI_FLAG   = 8'h10;
	localparam logic [7:0] OFF_NMI_CLEAR  = 8'h14;
	localparam logic [7:0] OFF_NMI_FORCE  = 8'h18;
	localparam logic [7:0] OFF_FT_PERIOD  = 8'h1C;
	localparam logic [7:0] OFF_FT_COUNT   = 8'h20;
	localparam logic [7:0] OFF_WD_KEY     = 8'h24;
	localparam logic [7:0] OFF_WD_CTRL    = 8'h28;
	localparam logic [7:0] OFF_WD_COUNT   = 8'h2C;

	// clock_source_control_reg fields
	localparam int SC_EXT_OFF  = 0;
	localparam int SC_XTAL_OFF = 1;
	localparam int SC_OSCA_OFF = 2;
	localparam int SC_OSCB_OFF = 3;
	localparam int SC_CORE_LO  = 4;
	localparam int SC_WD_SRC   = 6;
	localparam int SC_T2_SRC   = 7;
	localparam int SC_FAIL_SEL = 8;
	// ext_clock_config_reg field
	localparam int EC_PIN_SEL  = 0;
	// multiplier_state_reg fields
	localparam int MS_LOCKED   = 0;
	localparam int MS_PDOWN    = 1;
	localparam int MS_MISSING  = 3;
	localparam int MS_DIV_LO   = 7;
	// nonmask flag fields
	localparam int NF_NONMASK_INTERRUPT_FLAG    = 0;
	localparam int NF_FAIL     = 1;
	// watchdog control field
	localparam int WC_DISABLE  = 0;

	// reset values, watchdog keys and response codes
	localparam logic [15:0] FT_PERIOD_RST = 16'hFFFF;
	localparam logic [1:0]  OUTPUT_DIVIDER_SELECT_RST    = 2'h0;
	localparam logic [7:0]  WD_KEY_ARM    = 8'h55;
	localparam logic [7:0]  WD_KEY_CLEAR  = 8'hAA;
	localparam logic [7:0]  WD_MAX        = 8'hFF;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		SRC_OSC_A = 2'h0,
		SRC_OSC_B = 2'h1,
		SRC_XTAL  = 2'h2,
		SRC_EXT   = 2'h3
	} core_src_t;

	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b01,
		KEY_ARMED = 2'b10
	} key_state_t;

endpackage

// >>> logic/clock_div_gen.sv
// multiplier emulation and output divider producing the core clock enable
`timescale 1ns/1ps
module clock_div_gen
	import clk_ctrl_pkg::*;
#(
	parameter int CREDIT_W = 5
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// clock events
	input  wire logic              src_tick,
	input  wire logic              limp_tick,
	input  wire logic              limp_on,
	// setting
	input  wire logic              mult_on,
	input  wire logic [MULT_W-1:0] mult_n,
	input  wire logic [1:0]        output_divider_select,
	// result
	output logic                   core_en
);

	logic [CREDIT_W-1:0] credit_r;
	logic [CREDIT_W-1:0] add;
	logic [1:0]          div_cnt_r;
	logic [1:0]          div_last;
	logic                tick;

	// each input edge yields n pulses when multiplying, one otherwise
	always_comb begin
		add = '0;
		if (limp_on ? limp_tick : src_tick) begin
			add = mult_on && !limp_on ? CREDIT_W'(mult_n) : CREDIT_W'(1);
		end
	end

	assign tick = credit_r != '0;

	always_comb begin
		case (output_divider_select)
			2'h2:    div_last = 2'h1;
			2'h3:    div_last = 2'h0;
			default: div_last = 2'h3;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			credit_r <= '0;
		end else begin
			credit_r <= credit_r + add - CREDIT_W'(tick);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt_r <= 2'h0;
			core_en   <= 1'b0;
		end else if (tick) begin
			if (div_cnt_r >= div_last) begin
				div_cnt_r <= 2'h0;
				core_en   <= 1'b1;
			end else begin
				div_cnt_r <= div_cnt_r + 2'h1;
				core_en   <= 1'b0;
			end
		end else begin
			core_en <= 1'b0;
		end
	end

	sequence div_wrap_s;
		tick && div_cnt_r >= div_last;
	endsequence

	div_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		div_wrap_s |=> core_en) else $error("divider missed output pulse");
	div_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(tick && div_cnt_r >= div_last) |=> !core_en) else $error("stray core pulse");

endmodule // clock_div_gen

// >>> logic/legacy_wdog.sv
// key-serviced 8-bit watchdog with a 512 oscillator-clock output pulse
`timescale 1ns/1ps
module legacy_wdog
	import clk_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// oscillator edge and control
	input  wire logic       osc_tick,
	input  wire logic       hold,
	input  wire logic       disable_cnt,
	// key writes
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	// status
	output logic [7:0]      count,
	output logic            wd_pulse
);

	key_state_t key_st;
	logic [8:0] pulse_cnt_r;
	logic       clr_w;

	assign clr_w = key_wr && key_data == WD_KEY_CLEAR && key_st == KEY_ARMED;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_st <= KEY_IDLE;
		end else if (key_wr) begin
			case (key_st)
				KEY_IDLE:  key_st <= key_data == WD_KEY_ARM ? KEY_ARMED : KEY_IDLE;
				KEY_ARMED: key_st <= key_data == WD_KEY_CLEAR ? KEY_IDLE : KEY_ARMED;
				default:   key_st <= KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= 8'h00;
		end else if (clr_w) begin
			count <= 8'h00;
		end else if (osc_tick && !hold && !disable_cnt && !wd_pulse) begin
			count <= count == WD_MAX ? 8'h00 : count + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_pulse    <= 1'b0;
			pulse_cnt_r <= 9'h000;
		end else if (!wd_pulse) begin
			pulse_cnt_r <= 9'h000;
			wd_pulse    <= osc_tick && !hold && !disable_cnt && !clr_w && count == WD_MAX;
		end else if (osc_tick) begin
			pulse_cnt_r <= pulse_cnt_r + 9'h001;
			wd_pulse    <= pulse_cnt_r != 9'(WDOG_PULSE_OSC - 1);
		end
	end

	sequence pulse_mid_s;
		wd_pulse && !(osc_tick && pulse_cnt_r == 9'(WDOG_PULSE_OSC - 1));
	endsequence

	wd_width_a: assert property (@(posedge clk) disable iff (!rst_n)
		pulse_mid_s |=> wd_pulse) else $error("watchdog pulse ended early");
	wd_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wd_pulse) |-> pulse_cnt_r == 9'h000 && $past(count) == WD_MAX) else $error("bad pulse start");
	wd_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold && !clr_w |=> $stable(count)) else $error("count moved in limp");
	key_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		clr_w |=> count == 8'h00) else $error("key sequence did not clear");

endmodule // legacy_wdog

// >>> logic/clock_source_pll_failsafe.sv
// clock source selection, multiplier modes, missing-clock fail-safe and register slave
`timescale 1ns/1ps

module clock_source_pll_failsafe
	import clk_ctrl_pkg::*;
#(
	parameter int LOCK_CYC = LOCK_CYCLES,
	parameter int MISS_CYC = MISS_CYCLES,
	parameter int LIMP_CYC = LIMP_DIV
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// axi4-lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// oscillator and clock pins
	input  wire logic              osc_a_pin,
	input  wire logic              osc_b_pin,
	input  wire logic              xtal_pins,
	input  wire logic              gpio19_pin,
	input  wire logic              gpio38_pin,
	// clock enables and events
	output logic                   system_clock_out,
	output logic                   timer2_clock_en,
	output logic                   limp_active,
	output logic                   nonmask_interrupt_flag,
	output logic                   fail_reset,
	output logic                   wdog_reset
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [4:0] pin_in;
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic [4:0] pin_d_r;
	logic [4:0] pin_edge;

	assign pin_in = {gpio38_pin, gpio19_pin, xtal_pins, osc_b_pin, osc_a_pin};

	for (genvar i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				pin_s1_r[i] <= 1'b0;
				pin_s2_r[i] <= 1'b0;
				pin_d_r[i]  <= 1'b0;
			end else begin
				pin_s1_r[i] <= pin_in[i];
				pin_s2_r[i] <= pin_s1_r[i];
				pin_d_r[i]  <= pin_s2_r[i];
			end
		end
		assign pin_edge[i] = pin_s2_r[i] && !pin_d_r[i];
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic              ext_off_r, xtal_off_r, osca_off_r, oscb_off_r;
	core_src_t         core_src_r;
	logic              wd_src_r, t2_src_r, fail_sel_r, pin_sel_r;
	logic [MULT_W-1:0] mult_n_r;
	logic              pdown_r;
	logic [1:0]        output_divider_select_r;
	logic              missing_clock_flag_r, clock_fail_flag_r;
	logic [15:0]       ft_period_r, ft_cnt_r;
	logic              wd_disable_r;
	logic [7:0]        wd_count;
	logic              locked_r;
	logic [31:0]       lock_cnt_r;

	// axi write side
	logic              aw_got_r, w_got_r;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_en;
	logic [31:0]       wmask, wval;
	logic [7:0]        woff, roff;

	function automatic logic mapped(input logic [7:0] off);
		mapped = off[1:0] == 2'h0 && off <= OFF_WD_COUNT;
	endfunction

	assign wr_en = aw_got_r && w_got_r && !bvalid;
	assign woff  = 8'(awaddr_q);
	assign roff  = 8'(araddr);
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wval  = wdata_q & wmask;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awready  <= 1'b0;
			wready   <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
		end else begin
			awready <= awvalid && !awready && !aw_got_r && !bvalid;
			wready  <= wvalid && !wready && !w_got_r && !bvalid;
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_en) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= mapped(woff) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// software control bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{ext_off_r, xtal_off_r, osca_off_r, oscb_off_r} <= 4'h0;
			core_src_r   <= SRC_OSC_A;
			{wd_src_r, t2_src_r, fail_sel_r, pin_sel_r} <= 4'h0;
			ft_period_r  <= FT_PERIOD_RST;
			wd_disable_r <= 1'b0;
		end else if (wr_en && woff == OFF_SRC_CTRL) begin
			ext_off_r  <= wmask[SC_EXT_OFF] ? wdata_q[SC_EXT_OFF] : ext_off_r;
			xtal_off_r <= wmask[SC_XTAL_OFF] ? wdata_q[SC_XTAL_OFF] : xtal_off_r;
			osca_off_r <= wmask[SC_OSCA_OFF] ? wdata_q[SC_OSCA_OFF] : osca_off_r;
			oscb_off_r <= wmask[SC_OSCB_OFF] ? wdata_q[SC_OSCB_OFF] : oscb_off_r;
			core_src_r <= wmask[SC_CORE_LO] ? core_src_t'(wdata_q[SC_CORE_LO +: 2]) : core_src_r;
			wd_src_r   <= wmask[SC_WD_SRC] ? wdata_q[SC_WD_SRC] : wd_src_r;
			t2_src_r   <= wmask[SC_T2_SRC] ? wdata_q[SC_T2_SRC] : t2_src_r;
			fail_sel_r <= wmask[SC_FAIL_SEL] ? wdata_q[SC_FAIL_SEL] : fail_sel_r;
		end else if (wr_en && woff == OFF_EXT_CFG && wstrb_q[0]) begin
			pin_sel_r <= wdata_q[EC_PIN_SEL];
		end else if (wr_en && woff == OFF_FT_PERIOD) begin
			ft_period_r <= (ft_period_r & ~wmask[15:0]) | wval[15:0];
		end else if (wr_en && woff == OFF_WD_CTRL && wstrb_q[0]) begin
			wd_disable_r <= wdata_q[WC_DISABLE];
		end
	end

	// multiplier registers survive fail resets
	always_ff @(posedge clk) begin
		if (!rst_n || wdog_reset) begin
			mult_n_r <= '0;
			pdown_r  <= 1'b0;
			output_divider_select_r <= OUTPUT_DIVIDER_SELECT_RST;
		end else if (wr_en && woff == OFF_MULT_CTRL && wstrb_q[0]) begin
			mult_n_r <= wdata_q[MULT_W-1:0];
		end else if (wr_en && woff == OFF_MULT_STATE) begin
			pdown_r  <= wmask[MS_PDOWN] ? wdata_q[MS_PDOWN] : pdown_r;
			output_divider_select_r <= wmask[MS_DIV_LO] ? wdata_q[MS_DIV_LO +: 2] : output_divider_select_r;
		end
	end

	// relock timer after any multiplier control write with byte lane 0 enabled
	always_ff @(posedge clk) begin
		if (!rst_n || wdog_reset) begin
			lock_cnt_r <= 32'h0000_0000;
			locked_r   <= 1'b0;
		end else if (wr_en && woff == OFF_MULT_CTRL && wstrb_q[0]) begin
			lock_cnt_r <= 32'h0000_0000;
			locked_r   <= 1'b0;
		end else if (!locked_r) begin
			lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
			locked_r   <= lock_cnt_r == 32'(LOCK_CYC - 1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source selection
	logic osca_tick, oscb_tick, xtal_tick, ext_tick, core_tick, wd_tick;

	assign osca_tick = pin_edge[0] && !osca_off_r;
	assign oscb_tick = pin_edge[1] && !oscb_off_r;
	assign xtal_tick = pin_edge[2] && !xtal_off_r;
	assign ext_tick  = !ext_off_r && (pin_sel_r ? pin_edge[4] : pin_edge[3]);
	assign wd_tick   = wd_src_r ? oscb_tick : osca_tick;

	always_comb begin
		case (core_src_r)
			SRC_OSC_A: core_tick = osca_tick;
			SRC_OSC_B: core_tick = oscb_tick;
			SRC_XTAL:  core_tick = xtal_tick;
			SRC_EXT:   core_tick = ext_tick;
			default:   core_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer2_clock_en <= 1'b0;
		end else begin
			timer2_clock_en <= t2_src_r ? oscb_tick : osca_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// missing clock, limp clock and fail flags
	logic [15:0] miss_cnt_r, limp_cnt_r;
	logic        miss_evt, fail_evt, limp_tick, flag_force, ft_fire;

	assign miss_evt   = !core_tick && miss_cnt_r == 16'(MISS_CYC - 1) && !missing_clock_flag_r;
	assign fail_evt   = miss_evt && !pdown_r;
	assign flag_force = wr_en && woff == OFF_NMI_FORCE && wval[NF_FAIL];
	assign limp_tick  = limp_cnt_r == 16'(LIMP_CYC - 1);
	assign ft_fire    = clock_fail_flag_r && ft_cnt_r == ft_period_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			miss_cnt_r <= 16'h0000;
			limp_cnt_r <= 16'h0000;
			limp_active <= 1'b0;
		end else begin
			miss_cnt_r <= core_tick ? 16'h0000 : miss_cnt_r + 16'(miss_cnt_r != 16'(MISS_CYC - 1));
			limp_cnt_r <= limp_tick ? 16'h0000 : limp_cnt_r + 16'h0001;
			limp_active <= missing_clock_flag_r && !pdown_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			missing_clock_flag_r   <= 1'b0;
			clock_fail_flag_r      <= 1'b0;
			nonmask_interrupt_flag <= 1'b0;
		end else begin
			if (miss_evt) begin
				missing_clock_flag_r <= 1'b1;
			end else if (wr_en && woff == OFF_MULT_STATE && wval[MS_MISSING]) begin
				missing_clock_flag_r <= 1'b0;
			end
			if (fail_evt || flag_force) begin
				clock_fail_flag_r      <= 1'b1;
				nonmask_interrupt_flag <= 1'b1;
			end else if (wr_en && woff == OFF_NMI_CLEAR) begin
				clock_fail_flag_r      <= clock_fail_flag_r && !wval[NF_FAIL];
				nonmask_interrupt_flag <= nonmask_interrupt_flag && !wval[NF_NONMASK_INTERRUPT_FLAG];
			end
		end
	end

	// fail timer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ft_cnt_r   <= 16'h0000;
			fail_reset <= 1'b0;
		end else begin
			ft_cnt_r   <= clock_fail_flag_r && !ft_fire ? ft_cnt_r + 16'h0001 : 16'h0000;
			fail_reset <= (fail_evt && fail_sel_r) || (ft_fire && !fail_sel_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core clock and watchdog
	clock_div_gen u_div (
		.clk       (clk),
		.rst_n     (rst_n),
		.src_tick  (core_tick),
		.limp_tick (limp_tick),
		.limp_on   (limp_active),
		.mult_on   (mult_n_r != '0 && locked_r && !pdown_r),
		.mult_n    (mult_n_r),
		.output_divider_select    (output_divider_select_r),
		.core_en   (system_clock_out)
	);

	legacy_wdog u_wdog (
		.clk         (clk),
		.rst_n       (rst_n),
		.osc_tick    (wd_tick),
		.hold        (missing_clock_flag_r),
		.disable_cnt (wd_disable_r),
		.key_wr      (wr_en && woff == OFF_WD_KEY && wstrb_q[0]),
		.key_data    (wdata_q[7:0]),
		.count       (wd_count),
		.wd_pulse    (wdog_reset)
	);

	////////////////////////////////////////////////////////////////////////
	// axi read side
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (roff)
			OFF_SRC_CTRL:   rd_val = 32'({fail_sel_r, t2_src_r, wd_src_r, core_src_r,
				oscb_off_r, osca_off_r, xtal_off_r, ext_off_r});
			OFF_EXT_CFG:    rd_val = 32'(pin_sel_r);
			OFF_MULT_CTRL:  rd_val = 32'(mult_n_r);
			OFF_MULT_STATE: rd_val = 32'({output_divider_select_r, 3'h0, missing_clock_flag_r, 1'b0,
				pdown_r, locked_r});
			OFF_NMI_FLAG:   rd_val = 32'({clock_fail_flag_r, nonmask_interrupt_flag});
			OFF_FT_PERIOD:  rd_val = 32'(ft_period_r);
			OFF_FT_COUNT:   rd_val = 32'(ft_cnt_r);
			OFF_WD_CTRL:    rd_val = 32'(wd_disable_r);
			OFF_WD_COUNT:   rd_val = 32'(wd_count);
			default:        rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= rd_val;
				rresp  <= mapped(roff) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	ext_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		ext_off_r && core_src_r == SRC_EXT |-> !core_tick) else $error("ext clock not forced low");
	fail_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		fail_evt |=> clock_fail_flag_r && nonmask_interrupt_flag && missing_clock_flag_r)
		else $error("clock fail not latched");
	imm_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		fail_evt && fail_sel_r |=> fail_reset) else $error("no immediate fail reset");
	timer_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
		ft_fire && !fail_sel_r |=> fail_reset && ft_cnt_r == 16'h0000)
		else $error("fail timer did not reset");
	relock_a: assert property (@(posedge clk) disable iff (!rst_n || wdog_reset)
		wr_en && woff == OFF_MULT_CTRL && wstrb_q[0] |=> !locked_r ##1 !locked_r)
		else $error("bypass not held during relock");
	pdown_limp_a: assert property (@(posedge clk) disable iff (!rst_n)
		pdown_r && $past(pdown_r) |-> !limp_active) else $error("limp clock in off mode");
	force_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		flag_force |=> clock_fail_flag_r) else $error("force did not set flag");

endmodule // clock_source_pll_failsafe

// >>> dv/osc_src_model.sv
// free-running oscillator, crystal and external clock pins with per-pin stop
`timescale 1ns/1ps
module osc_src_model #(
	parameter int HALF_NS = 40
) (
	// per-pin run enables
	input  wire logic [4:0] run,
	// clock pins: osc a, osc b, crystal, pin 19, pin 38
	output logic      [4:0] pins
);
	logic ph = 1'b0;
	always #(HALF_NS) ph = ~ph;
	// a stopped source holds its pin low
	assign pins = run & {5{ph}};
endmodule // osc_src_model

// >>> dv/tb_top.sv
// self-checking bench for the clock source and fail-safe block
`timescale 1ns/1ps
module tb_top
	import clk_ctrl_pkg::*;
;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd_v, v;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, system_clock_out, timer2_clock_en;
	logic limp_active, nonmask_interrupt_flag, fail_reset, wdog_reset;
	logic [4:0] run = 5'h1f, pins;
	integer seed = 32'hbcd8;
	int mismatches = 0, checks = 0, cyc = 0, c, c2, n, ds, t;
	osc_src_model u_osc (.run, .pins);
	clock_source_pll_failsafe #(.LOCK_CYC(200), .MISS_CYC(32), .LIMP_CYC(5)) u_dut (
		.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .osc_a_pin(pins[0]), .osc_b_pin(pins[1]), .xtal_pins(pins[2]),
		.gpio19_pin(pins[3]), .gpio38_pin(pins[4]), .system_clock_out, .timer2_clock_en,
		.limp_active, .nonmask_interrupt_flag, .fail_reset, .wdog_reset);
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic near(input int s, input int x);
		check(32'((s > x + 1 || s + 1 < x) ? s : x), 32'(x));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
		resp = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rready <= 0;
		rd_v = rdata;
		resp = rresp;
	endtask
	task automatic cnt(input int cy);
		c = 0;
		c2 = 0;
		repeat (cy) begin
			@(posedge clk);
			c += system_clock_out;
			c2 += timer2_clock_en;
		end
	endtask
	task automatic reset();
		run <= 5'h1f;
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		wr(OFF_WD_CTRL, 32'h0000_0001);
		wr(OFF_SRC_CTRL, 32'h0000_0001);
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		reset();
		rd(OFF_MULT_STATE);
		check(rd_v, 0);
		rd(8'h30);
		check(resp, RESP_SLVERR);
		wr(8'h30, 32'h0000_0001);
		check(resp, RESP_SLVERR);
		wr(OFF_FT_PERIOD, 32'h0000_ffff);
		check(resp, RESP_OKAY);
		wr(OFF_NMI_FORCE, 32'h0000_0002);
		rd(OFF_NMI_FLAG);
		check(rd_v, 32'h0000_0003);
		wr(OFF_NMI_CLEAR, 32'h0000_0003);
		rd(OFF_NMI_FLAG);
		check(rd_v, 0);
		$display("test reset_and_flags done");
		for (int i = 0; i < 8; i++) begin
			n = i ? 2 + ($unsigned($random(seed)) % 8) : 0;
			ds = $random(seed) & 3;
			wr(OFF_MULT_STATE, 0);
			wr(OFF_MULT_CTRL, 32'(n));
			cnt(160);
			near(c, 2);
			repeat (60) @(posedge clk);
			wr(OFF_MULT_STATE, 32'(ds) << MS_DIV_LO);
			cnt(800);
			near(c, 40 * (n ? n : 1) / (ds < 2 ? 4 : ds == 2 ? 2 : 1));
		end
		wr(OFF_MULT_CTRL, 0);
		wr(OFF_MULT_STATE, 32'h0000_0182);
		cnt(800);
		near(c, 40);
		wr(OFF_MULT_STATE, 0);
		$display("test multiplier done");
		for (int k = 0; k < 5; k++) begin
			run <= 5'h1f;
			wr(OFF_EXT_CFG, 32'(k == 4));
			wr(OFF_SRC_CTRL, 32'((k < 3 ? k : 3) << SC_CORE_LO));
			run <= 5'(1 << k);
			repeat (40) @(posedge clk);
			cnt(800);
			near(c, 10);
			near(c2, k ? 0 : 40);
		end
		wr(OFF_SRC_CTRL, 32'h0000_0031);
		repeat (60) @(posedge clk);
		check(limp_active, 1);
		check(nonmask_interrupt_flag, 1);
		rd(OFF_MULT_STATE);
		check(rd_v[MS_MISSING], 1);
		cnt(200);
		near(c, 10);
		run <= 5'h1f;
		wr(OFF_WD_CTRL, 0);
		rd(OFF_WD_COUNT);
		v = rd_v;
		cnt(400);
		rd(OFF_WD_COUNT);
		check(rd_v, v);
		$display("test sources_and_limp done");
		for (int s = 0; s < 2; s++) begin
			reset();
			wr(OFF_FT_PERIOD, 32'd100);
			wr(OFF_SRC_CTRL, (32'(s) << SC_FAIL_SEL) | 32'h1);
			run <= 5'h1e;
			for (t = 0; t < 2000 && fail_reset !== 1'b1; t++) @(posedge clk);
			check((t < (s ? 0 : 100) || t >= (s ? 60 : 160)) ? t : 0, 0);
		end
		$display("test fail_timer done");
		reset();
		wr(OFF_MULT_CTRL, 32'h0000_0005);
		wr(OFF_WD_CTRL, 0);
		repeat (2000) @(posedge clk);
		wr(OFF_WD_KEY, 32'h0000_0055);
		wr(OFF_WD_KEY, 32'h0000_00aa);
		rd(OFF_WD_COUNT);
		check(rd_v < 3 ? 0 : rd_v, 0);
		for (t = 0; t < 8000 && wdog_reset !== 1'b1; t++) @(posedge clk);
		for (t = 0; t < 12000 && wdog_reset === 1'b1; t++) @(posedge clk);
		near(t / 20, 512);
		rd(OFF_MULT_CTRL);
		check(rd_v, 0);
		$display("test watchdog done");
		stop_test();
	end
endmodule // tb_top
